/* File: hw/dhlc_regs.svh */
// constants for the dpll holdover and loop configuration block
`ifndef DHLC_REGS_SVH
`define DHLC_REGS_SVH
`define DHLC_CURRENT_INTEGRAL_FREQUENCY_W        19
`define DHLC_CLK_HZ        25000000
`define DHLC_FAST_AVG_S    480
`define DHLC_SLOW_AVG_S    6600
// cycle counts exceed 32 bits, so the product is formed at 38 bits
`define DHLC_FAST_AVG_CYC  (38'(`DHLC_FAST_AVG_S) * 38'(`DHLC_CLK_HZ))
`define DHLC_SLOW_AVG_CYC  (38'(`DHLC_SLOW_AVG_S) * 38'(`DHLC_CLK_HZ))
`define DHLC_AVG_SHIFT     4
`define DHLC_MC_MAX_UI     13'h1fff
`define DHLC_DAMPING_CODE_RST      3'h3
`define DHLC_FINE_CFG_RST  8'h00
`endif

/* File: hw/dhlc_pkg.sv */
// types for the dpll holdover and loop configuration block
package dhlc_pkg;
  typedef logic [18:0] dhlc_current_integral_frequency_t;
  // bandwidth codes for the loop filter
  typedef enum logic [3:0] {
    DHLC_BW_LOW = 4'h0,  // 0.5 mhz up to 4 hz
    DHLC_BW_8   = 4'h1,
    DHLC_BW_18  = 4'h2,
    DHLC_BW_35  = 4'h3,
    DHLC_BW_70  = 4'h4
  } dhlc_bw_e;
  // damping factor times ten
  typedef logic [7:0] dhlc_damping_code_t;
  typedef enum logic [2:0] {
    DHLC_FREE  = 3'h0,
    DHLC_PRE   = 3'h1,
    DHLC_PRE2  = 3'h2,
    DHLC_LOCK  = 3'h3,
    DHLC_LOL   = 3'h4,
    DHLC_HOLD  = 3'h5
  } dhlc_state_e;
  typedef struct packed {
    logic       manual_holdover_sel;
    logic       holdover_averaging_sel;
    logic       fast_avg_sel;
    logic       read_average_sel;
    logic [1:0] mini_holdover_frequency_sel;
    dhlc_current_integral_frequency_t holdover_frequency_value;
  } dhlc_ho_cfg_s;
  typedef struct packed {
    logic        automatic_bandwidth_en;
    logic        integral_limit_en;
    dhlc_bw_e    acquisition_bandwidth_setting;
    dhlc_bw_e    locked_bandwidth_setting;
    dhlc_bw_e    aux_bandwidth_setting;
    logic [2:0]  damping_code;
    logic [2:0]  aux_damping_code;
    logic        nearest_edge_disable;
    logic        multicycle_detector_en;
    logic        multicycle_in_loop_en;
    logic [12:0] coarse_limit_range;
    logic        early_late_en;
    logic [7:0]  early_late_cfg;
  } dhlc_loop_cfg_s;
endpackage : dhlc_pkg

/* File: hw/dhlc_core.sv */
// holdover, mini-holdover, bandwidth, damping and phase-detector control
`timescale 1ns/1ps
`include "dhlc_regs.svh"
// Operation
// - instantaneous holdover takes integral value at entry
// - averaged mode averages integral frequency while locked
// - fast select picks 8 or 110 minute period
// - fast and slow ready flags, live and latched
// - slow mode falls back fast then instantaneous
// - fast mode falls back to instantaneous
// - manual mode uses software 19-bit holdover value
// - read-average returns selected averager value
// - fast isolation enters mini-holdover at chosen frequency
// - mini-holdover ends on return, switch, holdover
// - manual mode overrides mini-holdover selection
// - auxiliary loop switches revertive only, mirrored states
// - auxiliary bandwidth 18, 35 or 70 hz
// - auto bandwidth picks acquisition until locked
// - integral limit freezes integrator at frequency limits
// - damping five below 4hz, 8hz code1 2.5
// - higher bandwidths map codes, saturating per bandwidth
// - multicycle detector records up to 8191 ui
// - nearest-edge when multicycle off and locked
// - multicycle enable and coarse range setting
// - multicycle in loop selectable, tracks while detector enabled
// - early/late detector enable and tuning fields
// - holdover only when no valid reference remains
module dhlc_core (
  input  wire logic                    core_clk,        // 25 mhz local clock
  input  wire logic                    nrst,            // async reset, active low
  input  wire dhlc_pkg::dhlc_ho_cfg_s  ho_cfg,          // holdover controls
  input  wire dhlc_pkg::dhlc_loop_cfg_s loop_cfg,       // loop controls
  input  wire dhlc_pkg::dhlc_current_integral_frequency_t    current_integral_frequency, // integral path value
  input  wire logic                    main_locked,     // main loop phase locked
  input  wire logic                    sel_ref_invalid, // selected reference declared invalid
  input  wire logic                    other_valid,     // another valid input exists
  input  wire logic                    fast_isolate,    // activity monitor isolation pulse
  input  wire logic                    ref_returned,    // selected reference back
  input  wire logic                    ref_changed,     // new selected reference chosen
  input  wire logic                    current_integral_frequency_at_limit,   // loop frequency at min or max
  input  wire logic                    aux_higher_valid,// better reference for aux loop
  input  wire logic [12:0]             phase_ui,        // measured phase error in ui
  input  wire logic                    latch_clear,     // clears latched ready flags
  output dhlc_pkg::dhlc_current_integral_frequency_t         holdover_current_integral_frequency_q, // frequency used while holding
  output dhlc_pkg::dhlc_current_integral_frequency_t         readback_q,      // holdover field read value
  output logic                         holdover_q,      // in holdover
  output logic                         mini_holdover_q, // in mini-holdover
  output logic                         fast_average_ready_q,  // live fast ready
  output logic                         slow_average_ready_q,  // live slow ready
  output logic                         fast_ready_latched_q,  // sticky fast ready
  output logic                         slow_ready_latched_q,  // sticky slow ready
  output dhlc_pkg::dhlc_bw_e           main_bw_q,       // main loop bandwidth in use
  output dhlc_pkg::dhlc_bw_e           aux_bw_q,        // aux loop bandwidth in use
  output dhlc_pkg::dhlc_damping_code_t         main_damping_code_q,     // main damping factor x10
  output dhlc_pkg::dhlc_damping_code_t         aux_damping_code_q,      // aux damping factor x10
  output logic                         integral_freeze_q, // integrator frozen
  output logic                         nearest_edge_q,  // nearest-edge locking active
  output logic                         mc_in_loop_q,    // multicycle output used in loop
  output logic [12:0]                  mc_phase_q,      // multicycle tracked phase
  output logic                         early_late_en_q, // fine detector enable
  output logic [7:0]                   early_late_cfg_q,// fine detector tuning
  output logic                         aux_revertive_q  // aux loop revertive switch request
);

  // ************************************************************
  // averagers
  // ************************************************************
  localparam logic [37:0] FAST_CYC = `DHLC_FAST_AVG_CYC;
  localparam logic [37:0] SLOW_CYC = `DHLC_SLOW_AVG_CYC;

  logic [37:0]         fast_cnt_q, slow_cnt_q;
  dhlc_pkg::dhlc_current_integral_frequency_t fast_avg_q, slow_avg_q;
  logic                fast_ok_q, slow_ok_q;

  // first-order iir average; a true boxcar would need far too much memory
  wire signed [19:0] fast_err = $signed({1'b0, current_integral_frequency}) -
                                $signed({1'b0, fast_avg_q});
  wire signed [19:0] slow_err = $signed({1'b0, current_integral_frequency}) -
                                $signed({1'b0, slow_avg_q});
  wire dhlc_pkg::dhlc_current_integral_frequency_t fast_avg_d =
    fast_avg_q + 19'(fast_err >>> `DHLC_AVG_SHIFT);
  wire dhlc_pkg::dhlc_current_integral_frequency_t slow_avg_d =
    slow_avg_q + 19'(slow_err >>> (`DHLC_AVG_SHIFT + 4));
  wire avg_run = main_locked & ~holdover_q;

  // averaging runs only while locked
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fast_avg_q <= 19'h00000;
      slow_avg_q <= 19'h00000;
      fast_cnt_q <= 38'h0;
      slow_cnt_q <= 38'h0;
      fast_ok_q  <= 1'b0;
      slow_ok_q  <= 1'b0;
    end else if (avg_run) begin
      fast_avg_q <= fast_avg_d;
      slow_avg_q <= slow_avg_d;
      if (fast_cnt_q >= FAST_CYC - 38'h1) fast_ok_q <= 1'b1;
      else fast_cnt_q <= fast_cnt_q + 38'h1;
      if (slow_cnt_q >= SLOW_CYC - 38'h1) slow_ok_q <= 1'b1;
      else slow_cnt_q <= slow_cnt_q + 38'h1;
    end
  end

  // ************************************************************
  // holdover selection
  // ************************************************************
  wire dhlc_pkg::dhlc_current_integral_frequency_t avg_pick = ho_cfg.fast_avg_sel ?
    (fast_ok_q ? fast_avg_q : current_integral_frequency) :
    (slow_ok_q ? slow_avg_q :
      (fast_ok_q ? fast_avg_q : current_integral_frequency));
  wire dhlc_pkg::dhlc_current_integral_frequency_t auto_pick = ho_cfg.holdover_averaging_sel ?
    avg_pick : current_integral_frequency;
  wire dhlc_pkg::dhlc_current_integral_frequency_t ho_pick = ho_cfg.manual_holdover_sel ?
    ho_cfg.holdover_frequency_value : auto_pick;
  // mini-holdover choice: 0 instantaneous, 1 fast, 2 slow, 3 auto pick
  wire dhlc_pkg::dhlc_current_integral_frequency_t mini_pick =
    ho_cfg.manual_holdover_sel ? ho_cfg.holdover_frequency_value :
    (ho_cfg.mini_holdover_frequency_sel == 2'h1) ? fast_avg_q :
    (ho_cfg.mini_holdover_frequency_sel == 2'h2) ? slow_avg_q :
    (ho_cfg.mini_holdover_frequency_sel == 2'h3) ? auto_pick :
    current_integral_frequency;
  wire enter_ho = sel_ref_invalid & ~other_valid & ~holdover_q;
  wire leave_ho = holdover_q & other_valid;
  wire enter_mini = fast_isolate & ~holdover_q & ~enter_ho;
  wire end_mini = ref_returned | ref_changed | enter_ho;

  // holdover state and its frozen frequency
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      holdover_q      <= 1'b0;
      mini_holdover_q <= 1'b0;
      holdover_current_integral_frequency_q <= 19'h00000;
    end else begin
      if (enter_ho) begin
        holdover_q      <= 1'b1;
        holdover_current_integral_frequency_q <= ho_pick;
      end else if (leave_ho) begin
        holdover_q <= 1'b0;
      end else if (enter_mini && !mini_holdover_q) begin
        holdover_current_integral_frequency_q <= mini_pick;
      end
      if (end_mini) mini_holdover_q <= 1'b0;
      else if (enter_mini) mini_holdover_q <= 1'b1;
    end
  end

  // ************************************************************
  // ready flags and readback
  // ************************************************************
  wire dhlc_pkg::dhlc_current_integral_frequency_t rd_d = ho_cfg.read_average_sel ?
    (ho_cfg.fast_avg_sel ? fast_avg_q : slow_avg_q) :
    ho_cfg.holdover_frequency_value;

  // set wins over clear on the latched copies
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fast_average_ready_q <= 1'b0;
      slow_average_ready_q <= 1'b0;
      fast_ready_latched_q <= 1'b0;
      slow_ready_latched_q <= 1'b0;
      readback_q           <= 19'h00000;
    end else begin
      fast_average_ready_q <= fast_ok_q;
      slow_average_ready_q <= slow_ok_q;
      fast_ready_latched_q <= fast_ok_q | (fast_ready_latched_q & ~latch_clear);
      slow_ready_latched_q <= slow_ok_q | (slow_ready_latched_q & ~latch_clear);
      readback_q           <= rd_d;
    end
  end

  // ************************************************************
  // bandwidth and damping
  // ************************************************************
  // aux loop only takes its three legal bandwidths; anything else maps to 18 hz
  wire dhlc_pkg::dhlc_bw_e aux_bw_d =
    (loop_cfg.aux_bandwidth_setting == dhlc_pkg::DHLC_BW_35 ||
     loop_cfg.aux_bandwidth_setting == dhlc_pkg::DHLC_BW_70) ?
    loop_cfg.aux_bandwidth_setting : dhlc_pkg::DHLC_BW_18;
  wire dhlc_pkg::dhlc_bw_e main_bw_d =
    (loop_cfg.automatic_bandwidth_en && !main_locked) ?
    loop_cfg.acquisition_bandwidth_setting :
    loop_cfg.locked_bandwidth_setting;

  // damping factor x10 from bandwidth and code
  function automatic dhlc_pkg::dhlc_damping_code_t damping_code_map(
    input dhlc_pkg::dhlc_bw_e bw,
    input logic [2:0]         code
  );
    dhlc_pkg::dhlc_damping_code_t f;
    case (code)
      3'h1:    f = 8'h0c;
      3'h2:    f = 8'h19;
      3'h3:    f = 8'h32;
      3'h4:    f = 8'h64;
      default: f = 8'hc8;
    endcase
    case (bw)
      dhlc_pkg::DHLC_BW_8:  damping_code_map = (code == 3'h1) ? 8'h19 : 8'h32;
      dhlc_pkg::DHLC_BW_18: damping_code_map = (f > 8'h32) ? 8'h32 : f;
      dhlc_pkg::DHLC_BW_35: damping_code_map = (f > 8'h64) ? 8'h64 : f;
      dhlc_pkg::DHLC_BW_70: damping_code_map = f;
      default:              damping_code_map = 8'h32;
    endcase
  endfunction : damping_code_map

  wire integ_freeze_d = loop_cfg.integral_limit_en & current_integral_frequency_at_limit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      main_bw_q         <= dhlc_pkg::DHLC_BW_LOW;
      aux_bw_q          <= dhlc_pkg::DHLC_BW_18;
      main_damping_code_q       <= 8'h32;
      aux_damping_code_q        <= 8'h32;
      integral_freeze_q <= 1'b0;
    end else begin
      main_bw_q         <= main_bw_d;
      aux_bw_q          <= aux_bw_d;
      main_damping_code_q       <= damping_code_map(main_bw_d, loop_cfg.damping_code);
      aux_damping_code_q        <= damping_code_map(aux_bw_d, loop_cfg.aux_damping_code);
      integral_freeze_q <= integ_freeze_d;
    end
  end

  // ************************************************************
  // phase detectors
  // ************************************************************
  wire [12:0] mc_lim = loop_cfg.coarse_limit_range;
  wire [12:0] mc_d = (phase_ui > mc_lim) ? mc_lim : phase_ui;
  wire ne_d = ~loop_cfg.multicycle_detector_en & main_locked &
              ~loop_cfg.nearest_edge_disable;

  // tracker keeps running while enabled even when out of the loop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mc_phase_q       <= 13'h0000;
      mc_in_loop_q     <= 1'b0;
      nearest_edge_q   <= 1'b0;
      early_late_en_q  <= 1'b0;
      early_late_cfg_q <= `DHLC_FINE_CFG_RST;
      aux_revertive_q  <= 1'b0;
    end else begin
      if (loop_cfg.multicycle_detector_en) mc_phase_q <= mc_d;
      mc_in_loop_q     <= loop_cfg.multicycle_in_loop_en &
                          loop_cfg.multicycle_detector_en;
      nearest_edge_q   <= ne_d;
      early_late_en_q  <= loop_cfg.early_late_en;
      early_late_cfg_q <= loop_cfg.early_late_cfg;
      aux_revertive_q  <= aux_higher_valid;
    end
  end

endmodule : dhlc_core

/* File: tb/dhlc_core_properties.sv */
// assertion checker for the holdover and loop control block
`timescale 1ns/1ps
module dhlc_chk (
  input wire logic                     core_clk,          // clock
  input wire logic                     nrst,              // reset
  input wire dhlc_pkg::dhlc_ho_cfg_s   ho_cfg,            // holdover cfg
  input wire dhlc_pkg::dhlc_loop_cfg_s loop_cfg,          // loop cfg
  input wire dhlc_pkg::dhlc_current_integral_frequency_t     current_integral_frequency, // integral
  input wire logic                     main_locked,       // locked
  input wire logic                     sel_ref_invalid,   // ref failed
  input wire logic                     other_valid,       // alt present
  input wire logic                     current_integral_frequency_at_limit,     // at limit
  input wire logic                     holdover_q,        // holding
  input wire dhlc_pkg::dhlc_current_integral_frequency_t     holdover_current_integral_frequency_q,   // held value
  input wire dhlc_pkg::dhlc_bw_e       main_bw_q,         // bw in use
  input wire dhlc_pkg::dhlc_damping_code_t     aux_damping_code_q,        // aux damping
  input wire logic                     integral_freeze_q, // frozen
  input wire logic                     nearest_edge_q     // nearest edge
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // one entry definition, so every entry check agrees on it
  wire entry = sel_ref_invalid && !other_valid && !holdover_q;
  sequence s_man; entry && ho_cfg.manual_holdover_sel; endsequence
  sequence s_inst;
    entry && !ho_cfg.manual_holdover_sel && !ho_cfg.holdover_averaging_sel;
  endsequence
  sequence s_top;
    loop_cfg.aux_bandwidth_setting == dhlc_pkg::DHLC_BW_70 && loop_cfg.aux_damping_code == 3'h5;
  endsequence
  property p_entry; entry |=> holdover_q; endproperty
  property p_hold; holdover_q ##1 holdover_q |-> $stable(holdover_current_integral_frequency_q); endproperty
  property p_man; s_man |=> holdover_current_integral_frequency_q == $past(ho_cfg.holdover_frequency_value); endproperty
  property p_inst; s_inst |=> holdover_current_integral_frequency_q == $past(current_integral_frequency); endproperty
  property p_acq;
    loop_cfg.automatic_bandwidth_en && !main_locked
      |=> main_bw_q == $past(loop_cfg.acquisition_bandwidth_setting);
  endproperty
  property p_lck;
    !loop_cfg.automatic_bandwidth_en |=> main_bw_q == $past(loop_cfg.locked_bandwidth_setting);
  endproperty
  property p_frz; loop_cfg.integral_limit_en && current_integral_frequency_at_limit |=> integral_freeze_q; endproperty
  property p_near;
    main_locked && !loop_cfg.multicycle_detector_en && !loop_cfg.nearest_edge_disable
      |=> nearest_edge_q;
  endproperty
  property p_pfd; loop_cfg.nearest_edge_disable |=> !nearest_edge_q; endproperty
  property p_damping_code; s_top [*3] |-> aux_damping_code_q == 8'hc8; endproperty
  a_entry: assert property (p_entry) else $error("holdover not entered");
  a_hold: assert property (p_hold) else $error("held frequency moved");
  a_man: assert property (p_man) else $error("manual value not used");
  a_inst: assert property (p_inst) else $error("integral value not used");
  a_acq: assert property (p_acq) else $error("acquisition bw not used");
  a_lck: assert property (p_lck) else $error("locked bw not used");
  a_frz: assert property (p_frz) else $error("integrator not frozen");
  a_near: assert property (p_near) else $error("nearest edge not active");
  a_pfd: assert property (p_pfd) else $error("nearest edge not disabled");
  a_damping_code: assert property (p_damping_code) else $error("aux damping wrong");
endmodule : dhlc_chk
bind dhlc_core dhlc_chk u_chk (
  .core_clk, .nrst, .ho_cfg, .loop_cfg, .current_integral_frequency, .main_locked,
  .sel_ref_invalid, .other_valid, .current_integral_frequency_at_limit, .holdover_q, .holdover_current_integral_frequency_q,
  .main_bw_q, .aux_damping_code_q, .integral_freeze_q, .nearest_edge_q
);

/* File: tb/dhlc_ref_model.sv */
// line-card reference model: isolation, invalidation and recovery events
`timescale 1ns/1ps
module dhlc_ref_model (
  core_clk,        // clock
  nrst,            // reset
  fail_req,        // selected reference stops
  alt_req,         // another valid clock offered
  fast_isolate,    // isolation pulse
  sel_ref_invalid, // failure declared
  other_valid,     // alternative valid
  ref_returned,    // reference back
  ref_changed      // new reference chosen
);
  input  wire logic core_clk;
  input  wire logic nrst;
  input  wire logic fail_req;
  input  wire logic alt_req;
  output wire logic fast_isolate;
  output wire logic sel_ref_invalid;
  output wire logic other_valid;
  output wire logic ref_returned;
  output wire logic ref_changed;
  logic       fail_q;
  logic [1:0] age_q;
  // invalidation lags isolation, so mini-holdover is seen before holdover
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fail_q <= 1'b0;
      age_q  <= 2'h0;
    end else begin
      fail_q <= fail_req;
      age_q  <= !fail_req ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
    end
  end
  // isolation and return events are one cycle wide, invalidation is a level; the model never reselects by itself
  assign fast_isolate    = fail_req && !fail_q;
  assign ref_returned    = !fail_req && fail_q;
  assign sel_ref_invalid = age_q == 2'h3;
  assign other_valid     = alt_req;
  assign ref_changed     = 1'b0;
endmodule : dhlc_ref_model

/* File: tb/testbench.sv */
// self-checking bench for the holdover and loop control block
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  dhlc_pkg::dhlc_ho_cfg_s ho_cfg;
  dhlc_pkg::dhlc_loop_cfg_s loop_cfg;
  dhlc_pkg::dhlc_current_integral_frequency_t current_integral_frequency, holdover_current_integral_frequency_q;
  dhlc_pkg::dhlc_damping_code_t main_damping_code_q, aux_damping_code_q;
  dhlc_pkg::dhlc_bw_e main_bw_q, aux_bw_q;
  logic [12:0] phase_ui, mc_phase_q;
  logic [7:0] early_late_cfg_q;
  logic main_locked, current_integral_frequency_at_limit, fail_req, alt_req, holdover_q, mini_holdover_q;
  logic integral_freeze_q, nearest_edge_q, mc_in_loop_q, early_late_en_q;
  logic aux_higher_valid, aux_revertive_q, fast_rdy, slow_rdy, fast_lat, slow_lat;
  dhlc_pkg::dhlc_current_integral_frequency_t readback_q;
  logic fast_isolate, sel_ref_invalid, other_valid, ref_returned, ref_changed;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #20 core_clk = ~core_clk;
  dhlc_core dut (
    .core_clk, .nrst, .ho_cfg, .loop_cfg, .current_integral_frequency, .main_locked,
    .sel_ref_invalid, .other_valid, .fast_isolate, .ref_returned, .ref_changed,
    .current_integral_frequency_at_limit, .aux_higher_valid, .phase_ui, .latch_clear(1'b0),
    .holdover_current_integral_frequency_q, .readback_q, .holdover_q, .mini_holdover_q,
    .fast_average_ready_q(fast_rdy), .slow_average_ready_q(slow_rdy),
    .fast_ready_latched_q(fast_lat), .slow_ready_latched_q(slow_lat),
    .main_bw_q, .aux_bw_q, .main_damping_code_q, .aux_damping_code_q,
    .integral_freeze_q, .nearest_edge_q, .mc_in_loop_q, .mc_phase_q, .early_late_en_q,
    .early_late_cfg_q, .aux_revertive_q
  );
  dhlc_ref_model u_ref (
    .core_clk, .nrst, .fail_req, .alt_req, .fast_isolate, .sel_ref_invalid, .other_valid,
    .ref_returned, .ref_changed
  );
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wait_ho(input logic v);
    for (int i = 0; i < 20 && holdover_q !== v; i++) begin
      step(1);
    end
    chk("holdover_q", holdover_q, v);
  endtask : wait_ho
  task automatic t_holdover();
    alt_req = 1'b1;
    fail_req = 1'b1;
    step(6);
    chk("no entry with alternative", holdover_q, 1'b0);
    ho_cfg.manual_holdover_sel = 1'b1;
    ho_cfg.holdover_frequency_value = 19'h5a5a5;
    alt_req = 1'b0;
    wait_ho(1'b1);
    chk("manual current_integral_frequency", holdover_current_integral_frequency_q, 19'h5a5a5);
    current_integral_frequency = 19'h01234;
    step(3);
    chk("held current_integral_frequency", holdover_current_integral_frequency_q, 19'h5a5a5);
    alt_req = 1'b1;
    wait_ho(1'b0);
    ho_cfg.manual_holdover_sel = 1'b0;
    fail_req = 1'b0;
    alt_req = 1'b0;
    current_integral_frequency = 19'h3c3c3;
    step(2);
    fail_req = 1'b1;
    wait_ho(1'b1);
    chk("instant current_integral_frequency", holdover_current_integral_frequency_q, 19'h3c3c3);
    alt_req = 1'b1;
    fail_req = 1'b0;
    step(3);
  endtask : t_holdover
  task automatic t_mini();
    fail_req = 1'b1;
    step(1);
    chk("mini entry", mini_holdover_q, 1'b1);
    step(4);
    chk("mini stays", mini_holdover_q, 1'b1);
    fail_req = 1'b0;
    step(2);
    chk("mini return", mini_holdover_q, 1'b0);
    fail_req = 1'b1;
    step(1);
    alt_req = 1'b0;
    wait_ho(1'b1);
    chk("mini on holdover", mini_holdover_q, 1'b0);
    alt_req = 1'b1;
    fail_req = 1'b0;
    step(3);
  endtask : t_mini
  task automatic t_bw();
    loop_cfg.acquisition_bandwidth_setting = dhlc_pkg::DHLC_BW_70;
    loop_cfg.locked_bandwidth_setting = dhlc_pkg::DHLC_BW_LOW;
    for (int i = 0; i < 4; i++) begin
      loop_cfg.automatic_bandwidth_en = i[1];
      main_locked = i[0];
      step(2);
      chk("main bw", main_bw_q, (i == 2) ? 32'h4 : 32'h0);
    end
    for (int i = 2; i < 5; i++) begin
      loop_cfg.aux_bandwidth_setting = dhlc_pkg::dhlc_bw_e'(i[3:0]);
      step(2);
      chk("aux bw", aux_bw_q, 32'(i));
    end
  endtask : t_bw
  task automatic t_damping_code();
    // bandwidth, code, factor x10; 70 hz code 5 stays three cycles
    logic [15:0] tbl [10] = '{16'h0132, 16'h1119, 16'h1232, 16'h210c, 16'h2219,
                              16'h2532, 16'h3464, 16'h3564, 16'h45c8, 16'h4332};
    loop_cfg.automatic_bandwidth_en = 1'b0;
    for (int i = 0; i < 10; i++) begin
      loop_cfg.locked_bandwidth_setting = dhlc_pkg::dhlc_bw_e'(tbl[i][15:12]);
      loop_cfg.damping_code = tbl[i][10:8];
      // aux loop only has 18, 35 and 70 hz; lower rows park it at 18 hz
      loop_cfg.aux_bandwidth_setting = (tbl[i][15:12] >= 4'h2) ?
        dhlc_pkg::dhlc_bw_e'(tbl[i][15:12]) : dhlc_pkg::DHLC_BW_18;
      loop_cfg.aux_damping_code = tbl[i][10:8];
      step(3);
      chk("main damping_code", main_damping_code_q, tbl[i][7:0]);
      if (tbl[i][15:12] >= 4'h2) chk("aux damping_code", aux_damping_code_q, tbl[i][7:0]);
    end
  endtask : t_damping_code
  task automatic t_misc();
    loop_cfg.integral_limit_en = 1'b1;
    current_integral_frequency_at_limit = 1'b1;
    step(2);
    chk("freeze", integral_freeze_q, 1'b1);
    current_integral_frequency_at_limit = 1'b0;
    main_locked = 1'b1;
    step(2);
    chk("unfreeze", integral_freeze_q, 1'b0);
    chk("nearest edge", nearest_edge_q, 1'b1);
    loop_cfg.nearest_edge_disable = 1'b1;
    loop_cfg.multicycle_detector_en = 1'b1;
    loop_cfg.multicycle_in_loop_en = 1'b1;
    loop_cfg.coarse_limit_range = 13'h0010;
    phase_ui = 13'h0100;
    loop_cfg.early_late_en = 1'b1;
    loop_cfg.early_late_cfg = 8'h5c;
    aux_higher_valid = 1'b1;
    ho_cfg.holdover_frequency_value = 19'h2aaaa;
    ho_cfg.read_average_sel = 1'b0;
    step(2);
    chk("aux revertive", aux_revertive_q, 1'b1);
    chk("readback field", readback_q, 19'h2aaaa);
    chk("fast ready early", fast_rdy, 1'b0);
    chk("slow ready early", slow_rdy, 1'b0);
    chk("fast latched early", fast_lat, 1'b0);
    chk("slow latched early", slow_lat, 1'b0);
    chk("forced pfd", nearest_edge_q, 1'b0);
    chk("mc clamp", mc_phase_q, 13'h0010);
    chk("mc in loop", mc_in_loop_q, 1'b1);
    chk("fine en", early_late_en_q, 1'b1);
    chk("fine cfg", early_late_cfg_q, 8'h5c);
    loop_cfg.multicycle_in_loop_en = 1'b0;
    phase_ui = 13'h0008;
    step(2);
    chk("mc tracks unused", mc_phase_q, 13'h0008);
  endtask : t_misc
  // hang guard: the whole run needs under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    ho_cfg = '0;
    loop_cfg = '0;
    loop_cfg.aux_bandwidth_setting = dhlc_pkg::DHLC_BW_18;
    current_integral_frequency = 19'h00000;
    phase_ui = 13'h0000;
    main_locked = 1'b0;
    current_integral_frequency_at_limit = 1'b0;
    aux_higher_valid = 1'b0;
    fail_req = 1'b0;
    alt_req = 1'b0;
    step(1);
    chk("reset aux bw", aux_bw_q, 32'h2);
    chk("reset damping_code", main_damping_code_q, 8'h32);
    step(1);
    nrst = 1'b1;
    t_holdover();
    t_mini();
    t_bw();
    t_damping_code();
    t_misc();
    end_of_test();
  end
endmodule : testbench
